// File: bpq_query_engine.sv
`timescale 1ns/1ns
`include "bpq_params.svh"
module bpq_query_engine #(
    parameter logic [15:0] PROTO_ID    = 16'h5a17,            // arbitrary value
    parameter logic [47:0] MAC_ADDR    = 48'h0200_0000_0001,  // arbitrary value
    parameter int unsigned TICK_CYCLES = `BPQ_TICK_CYCLES
) (
    input  wire logic                 clk_sys,
    input  wire logic                 arst_n,
    input  wire bpq_pkg::bpq_byte_t   rxIn,
    output logic                      rxReady,
    output bpq_pkg::bpq_byte_t        txOut,
    input  wire logic                 txReady,
    input  wire logic signed [31:0]   posValue,
    input  wire logic signed [31:0]   speedValue,
    input  wire bpq_pkg::bpq_health_t health,
    input  wire logic                 switchIn1,
    input  wire logic                 switchIn2,
    output logic                      laserEnable,
    output bpq_pkg::bpq_net_t         netCfg,
    output logic                      useStaticAddr,
    output logic [47:0]               macAddr,
    input  wire logic [7:0]           regAddr,
    input  wire logic [31:0]          regWdata,
    input  wire logic                 regWe,
    input  wire logic                 regRe,
    output logic [31:0]               regRdata
);

    bpq_pkg::bpq_regs_t s_r;
    bpq_pkg::bpq_regs_t s_nxt;

    logic        rxDone;
    logic        qryOk;
    logic        cmdFire;
    logic [7:0]  cmdCode;
    logic        cycDue;
    logic        launch;
    logic        cycStart;
    logic [1:0]  ansKind;
    logic [15:0] ansId;
    logic        laserNxt;
    logic [25:0] posMag;
    logic [25:0] velMag;
    logic [25:0] selMag;

    // {overflow, sign, magnitude}; overflowed magnitude saturates
    function automatic logic [25:0] bpqMag(input logic signed [31:0] v);
        logic [31:0] m;
        m = v[31] ? 32'(-v) : 32'(v);
        return {|m[31:24], v[31], (|m[31:24]) ? 24'hff_ffff : m[23:0]};
    endfunction : bpqMag

    assign rxReady       = (s_r.fsm == bpq_pkg::BPQ_IDLE);
    assign txOut.valid   = (s_r.fsm == bpq_pkg::BPQ_SEND);
    assign txOut.data    = s_r.ans[0];
    assign txOut.last    = (s_r.txLeft == 4'h1);
    assign laserEnable   = s_r.laserOn;
    assign netCfg        = s_r.net;
    assign useStaticAddr = !s_r.net.dhcpOn;
    assign macAddr       = MAC_ADDR;
    assign regRdata      = s_r.rdData;

    // last byte of the query is the function code and is checked in flight
    always_comb
    begin
        rxDone  = rxIn.valid && rxReady && rxIn.last;
        cmdCode = rxIn.data;
        qryOk   = (s_r.rxCnt == `BPQ_QRY_LAST_IDX)
                  && ({s_r.qry[2], s_r.qry[3]} == PROTO_ID)
                  && ({s_r.qry[4], s_r.qry[5]} == `BPQ_QRY_LEN)
                  && (s_r.qry[6] == `BPQ_RESERVE_BYTE)
                  && (cmdCode >= `BPQ_FN_POS) && (cmdCode <= `BPQ_FN_BOTH);
        cmdFire = rxDone && qryOk;
        cycDue  = (s_r.cycMode != bpq_pkg::BPQ_CYC_OFF) && s_r.cycPend;
        launch  = cmdFire || (rxReady && !rxDone && cycDue);
        cycStart = cmdFire && (cmdCode == `BPQ_FN_CYC_POS || cmdCode == `BPQ_FN_CYC_VEL);
        laserNxt = s_r.laserOn;
        if (cmdFire && cmdCode == `BPQ_FN_LASER_ON)
        begin
            laserNxt = 1'b1;
        end
        else if (cmdFire && cmdCode == `BPQ_FN_LASER_OFF)
        begin
            laserNxt = 1'b0;
        end
        ansKind = 2'd0;
        ansId   = s_r.txId;
        if (cmdFire)
        begin
            ansId = {s_r.qry[0], s_r.qry[1]};
            if (cmdCode == `BPQ_FN_VEL || cmdCode == `BPQ_FN_CYC_VEL)
            begin
                ansKind = 2'd1;
            end
            else if (cmdCode == `BPQ_FN_BOTH)
            begin
                ansKind = 2'd2;
            end
        end
        else if (s_r.cycMode == bpq_pkg::BPQ_CYC_VEL)
        begin
            ansKind = 2'd1;
        end
        posMag = bpqMag(posValue);
        velMag = bpqMag(speedValue);
        selMag = (ansKind == 2'd1) ? velMag : posMag;
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ioSync1 = {switchIn2, switchIn1};
        s_nxt.ioSync2 = s_r.ioSync1;
        s_nxt.laserOn = laserNxt;

        // query capture
        if (rxIn.valid && rxReady)
        begin
            if (s_r.rxCnt < `BPQ_QRY_LAST_IDX)
            begin
                s_nxt.qry[s_r.rxCnt[2:0]] = rxIn.data;
            end
            if (s_r.rxCnt != 4'hf)
            begin
                s_nxt.rxCnt = s_r.rxCnt + 4'h1;
            end
            if (rxIn.last)
            begin
                s_nxt.rxCnt = 4'h0;
            end
        end

        // cyclic mode control
        if (cmdFire)
        begin
            case (cmdCode)
                `BPQ_FN_CYC_POS:  s_nxt.cycMode = bpq_pkg::BPQ_CYC_POS;
                `BPQ_FN_CYC_VEL:  s_nxt.cycMode = bpq_pkg::BPQ_CYC_VEL;
                `BPQ_FN_CYC_STOP: s_nxt.cycMode = bpq_pkg::BPQ_CYC_OFF;
                default:          s_nxt.cycMode = s_r.cycMode;
            endcase
            if (cmdCode == `BPQ_FN_CYC_POS || cmdCode == `BPQ_FN_CYC_VEL)
            begin
                s_nxt.txId    = ansId;
                s_nxt.cycCnt  = 16'h0;
                s_nxt.tickCnt = 16'h0;
                s_nxt.cycPend = 1'b0;
            end
        end

        // due answer taken before counting, so a period end in that cycle wins
        if (launch && !cmdFire)
        begin
            s_nxt.cycPend = 1'b0;
        end
        if (s_r.cycMode != bpq_pkg::BPQ_CYC_OFF && !cycStart)
        begin
            if (s_r.tickCnt == 16'(TICK_CYCLES - 1))
            begin
                s_nxt.tickCnt = 16'h0;
                if (s_r.cycCnt + 16'h1 >= s_r.cycPeriod)
                begin
                    s_nxt.cycCnt  = 16'h0;
                    s_nxt.cycPend = 1'b1;
                end
                else
                begin
                    s_nxt.cycCnt = s_r.cycCnt + 16'h1;
                end
            end
            else
            begin
                s_nxt.tickCnt = s_r.tickCnt + 16'h1;
            end
        end
        else
        begin
            s_nxt.cycPend = 1'b0;
        end

        case (s_r.fsm)
            bpq_pkg::BPQ_IDLE:
            begin
                if (launch)
                begin
                    s_nxt.ans[0]  = ansId[15:8];
                    s_nxt.ans[1]  = ansId[7:0];
                    s_nxt.ans[2]  = PROTO_ID[15:8];
                    s_nxt.ans[3]  = PROTO_ID[7:0];
                    s_nxt.ans[4]  = 8'h00;
                    s_nxt.ans[5]  = (ansKind == 2'd2) ? `BPQ_LEN_BOTH : `BPQ_LEN_ONE;
                    s_nxt.ans[6]  = `BPQ_RESERVE_BYTE;
                    s_nxt.ans[7]  = {1'b0, !laserNxt, s_r.ioSync2, 4'h0};
                    s_nxt.ans[8]  = {health.ready, health.laser_prefailure_warn,
                                     health.temperature_limit_warn, health.hwError,
                                     health.receive_level_warn,
                                     health.implausible_value_flag,
                                     selMag[25], selMag[24]};
                    s_nxt.ans[9]  = selMag[23:16];
                    s_nxt.ans[10] = selMag[15:8];
                    s_nxt.ans[11] = selMag[7:0];
                    s_nxt.ans[12] = velMag[15:8];
                    s_nxt.ans[13] = velMag[7:0];
                    s_nxt.txLeft  = (ansKind == 2'd2) ? `BPQ_FRAME_BOTH : `BPQ_FRAME_ONE;
                    s_nxt.txIdx   = 4'h0;
                    s_nxt.fsm     = bpq_pkg::BPQ_SEND;
                end
            end
            bpq_pkg::BPQ_SEND:
            begin
                if (txReady)
                begin
                    s_nxt.ans    = {8'h00, s_r.ans[13:1]};
                    s_nxt.txLeft = s_r.txLeft - 4'h1;
                    s_nxt.txIdx  = s_r.txIdx + 4'h1;
                    if (s_r.txLeft == 4'h1)
                    begin
                        s_nxt.fsm = bpq_pkg::BPQ_IDLE;
                    end
                end
            end
            default: s_nxt.fsm = bpq_pkg::BPQ_IDLE;
        endcase

        // register port
        s_nxt.rdData = 32'h0;
        if (regWe)
        begin
            if (regAddr == `BPQ_REG_CTRL)
            begin
                s_nxt.paramEdit = regWdata[0];
            end
            else if (regAddr == `BPQ_REG_IP && s_r.paramEdit)
            begin
                s_nxt.net.ip = regWdata;
            end
            else if (regAddr == `BPQ_REG_MASK && s_r.paramEdit)
            begin
                s_nxt.net.mask = regWdata;
            end
            else if (regAddr == `BPQ_REG_GW && s_r.paramEdit)
            begin
                s_nxt.net.gw = regWdata;
            end
            else if (regAddr == `BPQ_REG_DHCP && s_r.paramEdit)
            begin
                s_nxt.net.dhcpOn = regWdata[0];
            end
            else if (regAddr == `BPQ_REG_CYCLE)
            begin
                s_nxt.cycPeriod = (regWdata[15:0] == 16'h0) ? 16'h1 : regWdata[15:0];
            end
        end
        if (regRe)
        begin
            if (regAddr == `BPQ_REG_CTRL)
            begin
                s_nxt.rdData = {31'h0, s_r.paramEdit};
            end
            else if (regAddr == `BPQ_REG_IP)
            begin
                s_nxt.rdData = s_r.net.ip;
            end
            else if (regAddr == `BPQ_REG_MASK)
            begin
                s_nxt.rdData = s_r.net.mask;
            end
            else if (regAddr == `BPQ_REG_GW)
            begin
                s_nxt.rdData = s_r.net.gw;
            end
            else if (regAddr == `BPQ_REG_DHCP)
            begin
                s_nxt.rdData = {31'h0, s_r.net.dhcpOn};
            end
            else if (regAddr == `BPQ_REG_CYCLE)
            begin
                s_nxt.rdData = {16'h0, s_r.cycPeriod};
            end
            else if (regAddr == `BPQ_REG_STATUS)
            begin
                s_nxt.rdData = {25'h0, s_r.ioSync2, s_r.fsm, s_r.laserOn, s_r.cycMode,
                                s_r.cycPend};
            end
            else if (regAddr == `BPQ_REG_MAC_LO)
            begin
                s_nxt.rdData = MAC_ADDR[31:0];
            end
            else if (regAddr == `BPQ_REG_MAC_HI)
            begin
                s_nxt.rdData = {16'h0, MAC_ADDR[47:32]};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r            <= '0;
            s_r.laserOn    <= 1'b1;
            s_r.net.ip     <= `BPQ_RST_IP;
            s_r.net.mask   <= `BPQ_RST_MASK;
            s_r.net.gw     <= `BPQ_RST_GW;
            s_r.net.dhcpOn <= 1'b0;
            s_r.cycPeriod  <= `BPQ_RST_CYCLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence sFrameStart;
        txOut.valid && s_r.txIdx == 4'h0;
    endsequence
    sequence sQuery(logic [7:0] code);
        cmdFire && cmdCode == code;
    endsequence

    txid_echo_a: assert property (cmdFire |=> sFrameStart ##0 txOut.data == $past(ansId[15:8]))
        else $error("answer does not echo the transaction id");
    proto_echo_a: assert property (txOut.valid && s_r.txIdx == 4'h2 |-> txOut.data == PROTO_ID[15:8])
        else $error("protocol id high byte wrong");
    length_field_a: assert property (txOut.valid && s_r.txIdx == 4'h5 |-> txOut.data == `BPQ_LEN_ONE || txOut.data == `BPQ_LEN_BOTH)
        else $error("answer length field wrong");
    reserve_byte_a: assert property (txOut.valid && s_r.txIdx == 4'h6 |-> txOut.data == `BPQ_RESERVE_BYTE)
        else $error("reserve byte is not 0xff");
    status_zero_a: assert property (txOut.valid && s_r.txIdx == 4'h7 |-> txOut.data[7] == 1'b0 && txOut.data[3:0] == 4'h0)
        else $error("status byte 0 reserved bits set");
    both_length_a: assert property (sQuery(`BPQ_FN_BOTH) |=> s_r.txLeft == `BPQ_FRAME_BOTH)
        else $error("combined answer has wrong size");
    laser_cmd_a: assert property (sQuery(`BPQ_FN_LASER_OFF) |=> !laserEnable ##0 sFrameStart)
        else $error("laser did not switch off");
    cyc_stop_a: assert property (sQuery(`BPQ_FN_CYC_STOP) |=> s_r.cycMode == bpq_pkg::BPQ_CYC_OFF [*2])
        else $error("cyclic mode not stopped");
    discard_bad_a: assert property (rxDone && !qryOk && !cycDue |=> !txOut.valid)
        else $error("malformed query was answered");
    net_lock_a: assert property (regWe && !s_r.paramEdit && regAddr == `BPQ_REG_IP |=> $stable(netCfg.ip))
        else $error("address changed without edit enable");
    mac_read_a: assert property (regRe && regAddr == `BPQ_REG_MAC_LO |=> regRdata == MAC_ADDR[31:0])
        else $error("hardware address read wrong");

endmodule : bpq_query_engine

// File: bpq_params.svh
`ifndef BPQ_PARAMS_SVH
`define BPQ_PARAMS_SVH

// query and answer frame constants
`define BPQ_RESERVE_BYTE   8'hff
`define BPQ_QRY_LEN        16'h0002
`define BPQ_LEN_ONE        8'h06
`define BPQ_LEN_BOTH       8'h08
`define BPQ_FRAME_ONE      4'hc
`define BPQ_FRAME_BOTH     4'he
`define BPQ_QRY_LAST_IDX   4'h7

// function codes
`define BPQ_FN_POS         8'hf1
`define BPQ_FN_CYC_POS     8'hf2
`define BPQ_FN_CYC_STOP    8'hf3
`define BPQ_FN_LASER_ON    8'hf4
`define BPQ_FN_LASER_OFF   8'hf5
`define BPQ_FN_VEL         8'hf6
`define BPQ_FN_CYC_VEL     8'hf7
`define BPQ_FN_BOTH        8'hf8

// register byte addresses
`define BPQ_REG_CTRL       8'h00
`define BPQ_REG_IP         8'h04
`define BPQ_REG_MASK       8'h08
`define BPQ_REG_GW         8'h0c
`define BPQ_REG_DHCP       8'h10
`define BPQ_REG_CYCLE      8'h14
`define BPQ_REG_STATUS     8'h18
`define BPQ_REG_MAC_LO     8'h1c
`define BPQ_REG_MAC_HI     8'h20

// reset values
`define BPQ_RST_IP         32'hc0a8_0001
`define BPQ_RST_MASK       32'hffff_ff00
`define BPQ_RST_GW         32'h0000_0000
`define BPQ_RST_CYCLE      16'h000a

// output cycle tick of one millisecond
`define BPQ_CLK_NS         50
`define BPQ_TICK_NS        1000000
`define BPQ_TICK_CYCLES    (`BPQ_TICK_NS / `BPQ_CLK_NS)

`endif

// File: bpq_pkg.sv
package bpq_pkg;

    typedef enum logic [0:0] {
        BPQ_IDLE = 1'b0,
        BPQ_SEND = 1'b1
    } bpq_state_t;

    typedef enum logic [1:0] {
        BPQ_CYC_OFF = 2'b00,
        BPQ_CYC_POS = 2'b01,
        BPQ_CYC_VEL = 2'b11
    } bpq_cyc_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
    } bpq_byte_t;

    typedef struct packed {
        logic [31:0] ip;
        logic [31:0] mask;
        logic [31:0] gw;
        logic        dhcpOn;
    } bpq_net_t;

    typedef struct packed {
        logic ready;
        logic laser_prefailure_warn;
        logic temperature_limit_warn;
        logic hwError;
        logic receive_level_warn;
        logic implausible_value_flag;
    } bpq_health_t;

    typedef struct packed {
        bpq_state_t       fsm;
        logic [1:0]       ioSync1;
        logic [1:0]       ioSync2;
        logic [6:0][7:0]  qry;
        logic [3:0]       rxCnt;
        logic [13:0][7:0] ans;
        logic [3:0]       txLeft;
        logic [3:0]       txIdx;
        logic [15:0]      txId;
        bpq_cyc_t         cycMode;
        logic             cycPend;
        logic [15:0]      tickCnt;
        logic [15:0]      cycCnt;
        logic             laserOn;
        logic             paramEdit;
        bpq_net_t         net;
        logic [15:0]      cycPeriod;
        logic [31:0]      rdData;
    } bpq_regs_t;

endpackage : bpq_pkg

// File: bpq_host_model.sv
`timescale 1ns/1ns
module bpq_host_model (
    input  wire logic               clk_sys,
    input  wire logic               rxReady,
    output bpq_pkg::bpq_byte_t      rxIn,
    input  wire bpq_pkg::bpq_byte_t txOut,
    output logic                    txReady,
    input  wire logic               slowSink
);
    logic [7:0] ansBytes[$];
    int         frameLens[$];
    int         frameStarts[$];
    int         curLen = 0;
    int         cycleNo = 0;
    int         stalls = 0;

    initial
    begin
        rxIn    = '0;
        txReady = 1'b1;
    end

    always @(posedge clk_sys)
        txReady <= slowSink ? ~txReady : 1'b1;

    // sampled mid-cycle: the values that the next rising edge will see
    always @(negedge clk_sys)
    begin
        cycleNo++;
        if (txOut.valid && txReady)
        begin
            if (curLen == 0)
                frameStarts.push_back(cycleNo);
            ansBytes.push_back(txOut.data);
            curLen++;
            if (txOut.last)
            begin
                frameLens.push_back(curLen);
                curLen = 0;
            end
        end
    end

    // each byte held until an edge with ready high takes it
    task automatic send_query(input logic [7:0] q[8], input int n);
        int   w;
        logic rdy;
        for (int i = 0; i < n; i++)
        begin
            rxIn <= '{1'b1, q[i], i == n - 1};
            w = 0;
            do
            begin
                @(negedge clk_sys);
                rdy = rxReady;
                @(posedge clk_sys);
                w++;
            end while (!rdy && w < 300);
            if (!rdy)
                stalls++;
        end
        rxIn.valid <= 1'b0;
        // released data line shows the inverse, not a stale copy
        rxIn.data  <= ~q[n - 1];
    endtask : send_query
endmodule : bpq_host_model

// File: test_binary_position_query_protocol.sv
`timescale 1ns/1ns
`include "bpq_params.svh"
module test_binary_position_query_protocol;
    localparam int unsigned TICK = 4;
    localparam logic [15:0] PID  = 16'h3c5e;           // arbitrary value
    localparam logic [47:0] MAC  = 48'h0200_00ab_cdef; // arbitrary value
    typedef struct {
        logic [7:0]         code;
        logic [15:0]        id;
        logic signed [31:0] pos;
        logic signed [31:0] vel;
        logic [5:0]         hl;
        logic [1:0]         sw;
    } bpq_row_t;

    logic                 clk_sys;
    logic                 arst_n;
    logic                 slowSink;
    bpq_pkg::bpq_byte_t   rxIn;
    bpq_pkg::bpq_byte_t   txOut;
    logic                 rxReady;
    logic                 txReady;
    logic signed [31:0]   posValue;
    logic signed [31:0]   speedValue;
    bpq_pkg::bpq_health_t health;
    logic                 switchIn1;
    logic                 switchIn2;
    logic                 laserEnable;
    bpq_pkg::bpq_net_t    netCfg;
    logic                 useStaticAddr;
    logic [47:0]          macAddr;
    logic [7:0]           regAddr;
    logic [31:0]          regWdata;
    logic                 regWe;
    logic                 regRe;
    logic [31:0]          regRdata;
    logic [7:0]           expQ[$];
    logic                 laserExp;
    int                   err_total;
    int                   comparisons;
    int                   base;
    bpq_row_t             c;
    bpq_row_t             rows[6] = '{
        '{8'hf1, 16'h0000, 32'sh0012_d687, 32'sh0000_0005, 6'h20, 2'h0},
        '{8'hf6, 16'hffff, 32'sh0000_0000, -32'sh0001_1170, 6'h35, 2'h1},
        '{8'hf8, 16'h1234, -32'sh00ff_ffff, -32'sh0000_812c, 6'h2a, 2'h2},
        '{8'hf5, 16'h1235, 32'sh0100_0000, 32'sh0000_0000, 6'h00, 2'h3},
        '{8'hf1, 16'h1236, 32'sh0000_0001, 32'sh0000_0000, 6'h3f, 2'h0},
        '{8'hf4, 16'h1237, -32'sh0000_0001, 32'sh0000_0000, 6'h01, 2'h0}};

    bpq_query_engine #(.PROTO_ID(PID), .MAC_ADDR(MAC), .TICK_CYCLES(TICK)) u_dut (
        .clk_sys, .arst_n, .rxIn, .rxReady, .txOut, .txReady, .posValue, .speedValue,
        .health, .switchIn1, .switchIn2, .laserEnable, .netCfg, .useStaticAddr,
        .macAddr, .regAddr, .regWdata, .regWe, .regRe, .regRdata);

    bpq_host_model u_host (.clk_sys, .rxReady, .rxIn, .txOut, .txReady, .slowSink);

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWe    <= 1'b1;
        @(posedge clk_sys);
        regWe    <= 1'b0;
        @(posedge clk_sys);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        regAddr <= a;
        regRe   <= 1'b1;
        @(posedge clk_sys);
        regRe   <= 1'b0;
        #1;
        check(regRdata, exp);
        @(posedge clk_sys);
    endtask : reg_rd

    task automatic send(input logic [7:0] code, input logic [15:0] id, input int n = 8,
                        input logic [15:0] pid = PID, input logic [15:0] len = `BPQ_QRY_LEN,
                        input logic [7:0] res = `BPQ_RESERVE_BYTE);
        u_host.send_query('{id[15:8], id[7:0], pid[15:8], pid[7:0], len[15:8], len[7:0],
                            res, code}, n);
    endtask : send

    task automatic mk_exp(input bpq_row_t r);
        logic signed [31:0] v;
        logic [31:0]        m;
        logic [31:0]        s;
        logic               ovf;
        v   = (r.code == `BPQ_FN_VEL || r.code == `BPQ_FN_CYC_VEL) ? r.vel : r.pos;
        m   = v[31] ? -v : v;
        ovf = m > 32'h00ff_ffff;
        if (ovf)
            m = 32'h00ff_ffff;
        s   = r.vel[31] ? -r.vel : r.vel;
        expQ = '{r.id[15:8], r.id[7:0], PID[15:8], PID[7:0], 8'h00,
                 (r.code == `BPQ_FN_BOTH) ? `BPQ_LEN_BOTH : `BPQ_LEN_ONE, `BPQ_RESERVE_BYTE,
                 {1'b0, ~laserExp, r.sw, 4'h0}, {r.hl, ovf, v[31]}, m[23:16], m[15:8], m[7:0]};
        if (r.code == `BPQ_FN_BOTH)
        begin
            expQ.push_back(s[15:8]);
            expQ.push_back(s[7:0]);
        end
    endtask : mk_exp

    task automatic cmp_frame;
        int         w;
        int         n;
        logic [7:0] b;
        w = 0;
        while (u_host.frameLens.size() == 0 && w < 400)
        begin
            @(posedge clk_sys);
            w++;
        end
        if (u_host.frameLens.size() == 0)
        begin
            err_total++;
            $display("unexpected at %0t: no answer", $time);
            finish_test();
        end
        else
        begin
            n = u_host.frameLens.pop_front();
            check(n, expQ.size());
            for (int i = 0; i < n; i++)
            begin
                b = u_host.ansBytes.pop_front();
                if (i < expQ.size())
                    check(b, expQ[i]);
            end
        end
    endtask : cmp_frame

    task automatic run_row(input bpq_row_t r);
        posValue   <= r.pos;
        speedValue <= r.vel;
        health     <= r.hl;
        switchIn2  <= r.sw[1];
        switchIn1  <= r.sw[0];
        // switches pass a two-flop synchroniser first
        repeat (4) @(posedge clk_sys);
        if (r.code == `BPQ_FN_LASER_ON)
            laserExp = 1'b1;
        if (r.code == `BPQ_FN_LASER_OFF)
            laserExp = 1'b0;
        mk_exp(r);
        send(r.code, r.id);
        cmp_frame();
        check(laserEnable, laserExp);
    endtask : run_row

    task automatic stop_cyc(input logic [15:0] id);
        send(`BPQ_FN_CYC_STOP, id);
        repeat (80) @(posedge clk_sys);
        u_host.ansBytes.delete();
        u_host.frameLens.delete();
        repeat (120) @(posedge clk_sys);
        check(u_host.frameLens.size(), 0);
    endtask : stop_cyc

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        $display("unexpected at %0t: run too long", $time);
        finish_test();
    end

    initial
    begin
        err_total   = 0;
        comparisons = 0;
        laserExp    = 1'b1;
        arst_n      = 1'b0;
        slowSink    = 1'b0;
        posValue    = '0;
        speedValue  = '0;
        health      = '0;
        switchIn1   = 1'b0;
        switchIn2   = 1'b0;
        regAddr     = '0;
        regWdata    = '0;
        regWe       = 1'b0;
        regRe       = 1'b0;
        repeat (5) @(posedge clk_sys);
        #1;
        check(rxReady, 1'b1);
        check(txOut.valid, 1'b0);
        check(laserEnable, 1'b1);
        check(useStaticAddr, 1'b1);
        check(netCfg.ip, `BPQ_RST_IP);
        check(regRdata, 32'h0000_0000);
        @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        foreach (rows[i])
            run_row(rows[i]);
        // malformed queries: proto, length, reserve, two codes, short
        for (int k = 0; k < 6; k++)
        begin
            send(k == 4 ? 8'hf9 : k == 3 ? 8'hf0 : `BPQ_FN_POS, 16'h0100, k == 5 ? 7 : 8,
                 k == 0 ? ~PID : PID, k == 1 ? 16'h0003 : 16'h0002, k == 2 ? 8'hfe : 8'hff);
            repeat (30) @(posedge clk_sys);
            check(u_host.frameLens.size(), 0);
        end
        run_row(rows[0]);
        base = u_host.frameStarts.size();
        c = '{`BPQ_FN_CYC_POS, 16'h0042, 32'sh0000_0abc, 32'sh0000_0011, 6'h20, 2'h1};
        run_row(c);
        cmp_frame();
        cmp_frame();
        check(u_host.frameStarts[base + 2] - u_host.frameStarts[base + 1], 10 * TICK);
        stop_cyc(16'h0043);
        slowSink <= 1'b1;
        c = '{`BPQ_FN_CYC_VEL, 16'h0044, 32'sh0000_0001, -32'sh00ab_cdef, 6'h24, 2'h2};
        run_row(c);
        cmp_frame();
        stop_cyc(16'h0045);
        slowSink <= 1'b0;
        reg_rd(`BPQ_REG_MAC_LO, MAC[31:0]);
        reg_wr(`BPQ_REG_MAC_LO, 32'h0000_0000);
        reg_rd(`BPQ_REG_MAC_LO, MAC[31:0]);
        reg_rd(`BPQ_REG_MAC_HI, {16'h0000, MAC[47:32]});
        check(macAddr[31:0], MAC[31:0]);
        check({16'h0000, macAddr[47:32]}, {16'h0000, MAC[47:32]});
        reg_rd(`BPQ_REG_STATUS, 32'h0000_0048);
        reg_rd(`BPQ_REG_CYCLE, {16'h0000, `BPQ_RST_CYCLE});
        reg_wr(`BPQ_REG_IP, 32'h0a00_0005);
        reg_wr(`BPQ_REG_DHCP, 32'h0000_0001);
        reg_rd(`BPQ_REG_IP, `BPQ_RST_IP);
        check(useStaticAddr, 1'b1);
        reg_wr(`BPQ_REG_CTRL, 32'h0000_0001);
        reg_wr(`BPQ_REG_IP, 32'h0a00_0005);
        reg_wr(`BPQ_REG_GW, 32'h0a00_0001);
        reg_wr(`BPQ_REG_MASK, 32'hffff_0000);
        check(netCfg.mask, 32'hffff_0000);
        reg_wr(`BPQ_REG_DHCP, 32'h0000_0001);
        reg_rd(`BPQ_REG_IP, 32'h0a00_0005);
        check(netCfg.gw, 32'h0a00_0001);
        check(useStaticAddr, 1'b0);
        reg_rd(8'h3c, 32'h0000_0000);
        reg_wr(`BPQ_REG_CYCLE, 32'h0000_0000);
        reg_rd(`BPQ_REG_CYCLE, 32'h0000_0001);
        check(u_host.stalls, 0);
        finish_test();
    end
endmodule : test_binary_position_query_protocol
